// ===== ipc_pkg.sv
// shared constants and types for the paged i2c control port
package ipc_pkg;
	// target address: fixed prefix plus two strap bits
	localparam logic [4:0] ADDR_PREFIX = 5'h0b;
	localparam logic [1:0] STRAP_4K7 = 2'h0;
	localparam logic [1:0] STRAP_15K = 2'h1;
	localparam logic [1:0] STRAP_47K = 2'h2;
	localparam logic [1:0] STRAP_120K = 2'h3;
	////////////////////////////////////////////////////////////////////////////////
	// sub-addresses, books and pages
	localparam logic [7:0] SUB_PAGE = 8'h00;
	localparam logic [7:0] SUB_STATE = 8'h03;
	localparam logic [7:0] SUB_XOR = 8'h7d;
	localparam logic [7:0] SUB_CRC = 8'h7e;
	localparam logic [7:0] SUB_BOOK = 8'h7f;
	localparam logic [7:0] PAGE_ZERO = 8'h00;
	localparam logic [7:0] BOOK_ZERO = 8'h00;
	localparam logic [7:0] BOOK_XOR = 8'h8c;
	localparam logic [7:0] BOOK_COEF = 8'haa;
	localparam int COEF_PER_STAGE = 5;
	////////////////////////////////////////////////////////////////////////////////
	// checksum and reset values
	localparam logic [7:0] CRC_POLY = 8'h07;
	localparam logic [7:0] CSUM_RST = 8'h00;
	localparam logic [7:0] SEL_RST = 8'h00;
	// device state field encodings
	localparam logic [1:0] ST_DEEP_SLEEP = 2'h0;
	localparam logic [1:0] ST_SLEEP = 2'h1;
	localparam logic [1:0] ST_HIZ = 2'h2;
	localparam logic [1:0] ST_PLAY = 2'h3;
	localparam logic [1:0] STATE_RST = ST_DEEP_SLEEP;
	////////////////////////////////////////////////////////////////////////////////
	// timing
	localparam int CLK_SYS_HZ = 20_000_000;
	localparam int RATE_STD_KHZ = 100;
	localparam int RATE_FAST_KHZ = 400;
	localparam int T_PDN_WAIT_US = 5000;
	localparam int PDN_WAIT_CYC = T_PDN_WAIT_US * (CLK_SYS_HZ / 1_000_000);
	////////////////////////////////////////////////////////////////////////////////
	typedef enum logic [2:0] {
		DS_IDLE = 3'h0,
		DS_RX = 3'h1,
		DS_ACK = 3'h2,
		DS_TX = 3'h3,
		DS_MACK = 3'h4
	} ipc_dev_st_t;
	typedef enum logic [1:0] {
		BK_ADDR = 2'h0,
		BK_SUB = 2'h1,
		BK_DATA = 2'h2
	} ipc_byte_t;
	typedef enum logic [2:0] {
		HS_WAIT = 3'h0,
		HS_IDLE = 3'h1,
		HS_START = 3'h2,
		HS_BIT = 3'h3,
		HS_RSTART = 3'h4,
		HS_STOP = 3'h5
	} ipc_host_st_t;
	typedef enum logic [2:0] {
		HP_ADDR_W = 3'h0,
		HP_SUB = 3'h1,
		HP_WDATA = 3'h2,
		HP_ADDR_R = 3'h3,
		HP_RDATA = 3'h4
	} ipc_host_ph_t;
endpackage

// ===== ipc_link_if.sv
// open-drain i2c link, power-down pin and address strap between host and device
interface ipc_link_if;
	logic host_scl_o;
	logic host_scl_oe;
	logic host_sda_o;
	logic host_sda_oe;
	logic dev_sda_o;
	logic dev_sda_oe;
	logic scl;
	logic sda;
	logic power_down_pin;
	logic [1:0] strap;
	// wired-and with pull-up: a line is low while any enabled driver pulls low
	assign scl = !(host_scl_oe && !host_scl_o);
	assign sda = !((host_sda_oe && !host_sda_o) || (dev_sda_oe && !dev_sda_o));
	modport dev (
		input scl,
		input sda,
		input power_down_pin,
		input strap,
		output dev_sda_o,
		output dev_sda_oe
	);
	modport host (
		input sda,
		output host_scl_o,
		output host_scl_oe,
		output host_sda_o,
		output host_sda_oe,
		output power_down_pin,
		output strap
	);
endinterface

// ===== ipc_device.sv
// device end: i2c target with book/page select and crc/xor write checksums
//
// Summary of operation
// - i2c target, single/sequential writes and reads
// - sub-address 0 write selects page
// - address is 01011 plus two strap bits
// - strap code maps resistor to low bits
// - single write: address, sub, data acked
// - each written byte acked, sub-address increments
// - read: sub write, repeated start, byte
// - sequential read returns incrementing sub-addresses
// - 0x7f on page 0 selects book
// - host writes filter stage coefficients ascending
// - reads leave checksums; writes other than 0x00, 0x7e and 0x7f on page 0 update crc
// - crc and xor kept together, reloadable
// - crc polynomial 0x07 over written bytes
// - crc skips book/page writes, at 0x7e
// - xor only book 0x8c, not page 0
// - host sets strap, waits 5 ms after power-down release
// - host sequences hi-z, dsp, coefficients, play
// - state field at 0x03: deep sleep..play
module ipc_device (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	input wire logic i_clk_link,
	ipc_link_if.dev link,
	output logic [1:0] o_dev_state,
	output logic [7:0] o_book,
	output logic [7:0] o_page,
	output logic o_update
);
	// crc-8 step, msb of the byte shifted in first
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c;
		for (int i = 7; i >= 0; i--) begin
			if (r[7] ^ d[i]) begin
				r = {r[6:0], 1'b0} ^ ipc_pkg::CRC_POLY;
			end else begin
				r = {r[6:0], 1'b0};
			end
		end
		return r;
	endfunction

	logic [2:0] scl_sy_reg;
	logic [2:0] sda_sy_reg;
	logic [1:0] pdn_sy_reg;
	logic [1:0] strap_s1_reg;
	logic [1:0] strap_s2_reg;
	logic [1:0] strap_reg;
	logic rst_link;
	logic scl_rise;
	logic scl_fall;
	logic start_c;
	logic stop_c;
	ipc_pkg::ipc_dev_st_t st_reg;
	ipc_pkg::ipc_byte_t kind_reg;
	logic [3:0] cnt_reg;
	logic [7:0] sh_reg;
	logic [7:0] sub_reg;
	logic rw_reg;
	logic oe_reg;
	logic wr_stb_reg;
	logic [7:0] wr_sub_reg;
	logic [7:0] wr_data_reg;
	logic [7:0] page_reg;
	logic [7:0] book_reg;
	logic [7:0] crc_reg;
	logic [7:0] xsum_reg;
	logic [1:0] state_reg;
	logic [7:0] rd_byte;
	logic wr_dly_reg;
	logic [17:0] snap_reg;
	logic tgl_reg;
	logic [2:0] tgl_sy_reg;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers; stage 2 and its delayed copy feed the edge logic
	always_ff @(posedge i_clk_link) begin
		scl_sy_reg <= {scl_sy_reg[1:0], link.scl};
		sda_sy_reg <= {sda_sy_reg[1:0], link.sda};
		pdn_sy_reg <= {pdn_sy_reg[0], link.power_down_pin};
		strap_s1_reg <= link.strap;
		strap_s2_reg <= strap_s1_reg;
	end

	// power-down pin low holds the whole link side in reset
	assign rst_link = !pdn_sy_reg[1];
	assign scl_rise = scl_sy_reg[1] && !scl_sy_reg[2];
	assign scl_fall = !scl_sy_reg[1] && scl_sy_reg[2];
	assign start_c = scl_sy_reg[1] && scl_sy_reg[2] && sda_sy_reg[2] && !sda_sy_reg[1];
	assign stop_c = scl_sy_reg[1] && scl_sy_reg[2] && !sda_sy_reg[2] && sda_sy_reg[1];
	assign link.dev_sda_o = 1'b0;
	assign link.dev_sda_oe = oe_reg;

	// strap is caught while power-down is held, so a later change is ignored
	always_ff @(posedge i_clk_link) begin
		if (rst_link) begin
			strap_reg <= strap_s2_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// bit engine: shifts in on scl rise, shifts out and drives sda only after scl fall
	always_ff @(posedge i_clk_link) begin
		if (rst_link) begin
			st_reg <= ipc_pkg::DS_IDLE;
			kind_reg <= ipc_pkg::BK_ADDR;
			cnt_reg <= 4'h0;
			sh_reg <= 8'h00;
			sub_reg <= 8'h00;
			rw_reg <= 1'b0;
			oe_reg <= 1'b0;
			wr_stb_reg <= 1'b0;
			wr_sub_reg <= 8'h00;
			wr_data_reg <= 8'h00;
		end else begin
			wr_stb_reg <= 1'b0;
			if (start_c) begin
				// a repeated start also lands here and re-reads the direction
				st_reg <= ipc_pkg::DS_RX;
				kind_reg <= ipc_pkg::BK_ADDR;
				cnt_reg <= 4'h0;
				oe_reg <= 1'b0;
			end else if (stop_c) begin
				st_reg <= ipc_pkg::DS_IDLE;
				oe_reg <= 1'b0;
			end else begin
				unique case (st_reg)
					ipc_pkg::DS_IDLE: begin
						oe_reg <= 1'b0;
					end
					ipc_pkg::DS_RX: begin
						if (scl_rise) begin
							sh_reg <= {sh_reg[6:0], sda_sy_reg[1]};
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall && cnt_reg == 4'h8) begin
							cnt_reg <= 4'h0;
							unique case (kind_reg)
								ipc_pkg::BK_ADDR: begin
									if (sh_reg[7:1] == {ipc_pkg::ADDR_PREFIX, strap_reg}) begin
										rw_reg <= sh_reg[0];
										kind_reg <= ipc_pkg::BK_SUB;
										oe_reg <= 1'b1;
										st_reg <= ipc_pkg::DS_ACK;
									end else begin
										st_reg <= ipc_pkg::DS_IDLE;
									end
								end
								ipc_pkg::BK_SUB: begin
									sub_reg <= sh_reg;
									kind_reg <= ipc_pkg::BK_DATA;
									oe_reg <= 1'b1;
									st_reg <= ipc_pkg::DS_ACK;
								end
								default: begin
									wr_stb_reg <= 1'b1;
									wr_sub_reg <= sub_reg;
									wr_data_reg <= sh_reg;
									sub_reg <= sub_reg + 8'h01;
									oe_reg <= 1'b1;
									st_reg <= ipc_pkg::DS_ACK;
								end
							endcase
						end
					end
					ipc_pkg::DS_ACK: begin
						if (scl_fall) begin
							if (rw_reg) begin
								sh_reg <= rd_byte;
								oe_reg <= !rd_byte[7];
								st_reg <= ipc_pkg::DS_TX;
							end else begin
								oe_reg <= 1'b0;
								st_reg <= ipc_pkg::DS_RX;
							end
						end
					end
					ipc_pkg::DS_TX: begin
						if (scl_rise) begin
							cnt_reg <= cnt_reg + 4'h1;
						end else if (scl_fall) begin
							if (cnt_reg == 4'h8) begin
								oe_reg <= 1'b0;
								cnt_reg <= 4'h0;
								st_reg <= ipc_pkg::DS_MACK;
							end else begin
								sh_reg <= {sh_reg[6:0], 1'b0};
								oe_reg <= !sh_reg[6];
							end
						end
					end
					ipc_pkg::DS_MACK: begin
						// not-acknowledge ends the read; the stop that follows is awaited idle
						if (scl_rise) begin
							if (sda_sy_reg[1]) begin
								st_reg <= ipc_pkg::DS_IDLE;
							end else begin
								sub_reg <= sub_reg + 8'h01;
							end
						end else if (scl_fall) begin
							sh_reg <= rd_byte;
							oe_reg <= !rd_byte[7];
							st_reg <= ipc_pkg::DS_TX;
						end
					end
					default: begin
						st_reg <= ipc_pkg::DS_IDLE;
					end
				endcase
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// committed writes: selectors, checksums and the state field
	always_ff @(posedge i_clk_link) begin
		if (rst_link) begin
			page_reg <= ipc_pkg::SEL_RST;
			book_reg <= ipc_pkg::SEL_RST;
			crc_reg <= ipc_pkg::CSUM_RST;
			xsum_reg <= ipc_pkg::CSUM_RST;
			state_reg <= ipc_pkg::STATE_RST;
		end else if (wr_stb_reg) begin
			if (wr_sub_reg == ipc_pkg::SUB_PAGE) begin
				page_reg <= wr_data_reg;
			end else if (page_reg == ipc_pkg::PAGE_ZERO && wr_sub_reg == ipc_pkg::SUB_BOOK) begin
				book_reg <= wr_data_reg;
			end else if (page_reg == ipc_pkg::PAGE_ZERO && wr_sub_reg == ipc_pkg::SUB_CRC) begin
				crc_reg <= wr_data_reg;
			end else begin
				// unmapped sub-addresses still feed the crc, and the xor only in book 0x8c off page 0
				crc_reg <= crc_step(crc_reg, wr_data_reg);
				if (book_reg == ipc_pkg::BOOK_XOR && page_reg == ipc_pkg::PAGE_ZERO &&
					wr_sub_reg == ipc_pkg::SUB_XOR) begin
					xsum_reg <= wr_data_reg;
				end else if (book_reg == ipc_pkg::BOOK_XOR && page_reg != ipc_pkg::PAGE_ZERO) begin
					xsum_reg <= xsum_reg ^ wr_data_reg;
				end
				if (book_reg == ipc_pkg::BOOK_ZERO && page_reg == ipc_pkg::PAGE_ZERO &&
					wr_sub_reg == ipc_pkg::SUB_STATE) begin
					state_reg <= wr_data_reg[1:0];
				end
			end
		end
	end

	// read mux; anything unmapped reads zero and reads never touch checksums
	always_comb begin
		rd_byte = 8'h00;
		if (sub_reg == ipc_pkg::SUB_PAGE) begin
			rd_byte = page_reg;
		end else if (page_reg == ipc_pkg::PAGE_ZERO) begin
			if (sub_reg == ipc_pkg::SUB_BOOK) begin
				rd_byte = book_reg;
			end else if (sub_reg == ipc_pkg::SUB_CRC) begin
				rd_byte = crc_reg;
			end else if (sub_reg == ipc_pkg::SUB_XOR && book_reg == ipc_pkg::BOOK_XOR) begin
				rd_byte = xsum_reg;
			end else if (sub_reg == ipc_pkg::SUB_STATE && book_reg == ipc_pkg::BOOK_ZERO) begin
				rd_byte = {6'h00, state_reg};
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// snapshot and toggle together one cycle after a write; the word stays put for
	// a whole i2c byte, far longer than the toggle takes to cross
	always_ff @(posedge i_clk_link) begin
		if (rst_link) begin
			wr_dly_reg <= 1'b0;
			snap_reg <= 18'h00000;
			tgl_reg <= 1'b0;
		end else begin
			wr_dly_reg <= wr_stb_reg;
			if (wr_dly_reg) begin
				snap_reg <= {state_reg, book_reg, page_reg};
				tgl_reg <= !tgl_reg;
			end
		end
	end

	// system side: toggle synchroniser, edge detect on stage 2 and its copy
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			tgl_sy_reg <= 3'h0;
			o_dev_state <= ipc_pkg::STATE_RST;
			o_book <= ipc_pkg::SEL_RST;
			o_page <= ipc_pkg::SEL_RST;
			o_update <= 1'b0;
		end else begin
			tgl_sy_reg <= {tgl_sy_reg[1:0], tgl_reg};
			o_update <= tgl_sy_reg[1] ^ tgl_sy_reg[2];
			if (tgl_sy_reg[1] ^ tgl_sy_reg[2]) begin
				o_dev_state <= snap_reg[17:16];
				o_book <= snap_reg[15:8];
				o_page <= snap_reg[7:0];
			end
		end
	end
endmodule

// ===== ipc_host.sv
// host end: i2c master with divided scl, power-down release and strap drive
module ipc_host #(
	parameter int RATE_KHZ = ipc_pkg::RATE_STD_KHZ,
	parameter int PDN_WAIT_CYC = ipc_pkg::PDN_WAIT_CYC,
	parameter logic [1:0] STRAP = ipc_pkg::STRAP_4K7
) (
	input wire logic i_clk_sys,
	input wire logic i_rst,
	ipc_link_if.host link,
	input wire logic i_cmd_valid,
	input wire logic i_cmd_read,
	input wire logic [7:0] i_cmd_sub,
	input wire logic [7:0] i_cmd_len,
	input wire logic [7:0] i_wr_data,
	output logic o_ready,
	output logic o_nack,
	output logic [7:0] o_rd_data,
	output logic o_rd_valid,
	output logic o_wr_take
);
	// quarter of an scl period, rounded up so the rate never exceeds its figure
	localparam int QTR = (ipc_pkg::CLK_SYS_HZ + 4000 * RATE_KHZ - 1) / (4000 * RATE_KHZ);

	logic [15:0] qcnt_reg;
	logic tick;
	logic [1:0] sda_sy_reg;
	logic [31:0] wcnt_reg;
	ipc_pkg::ipc_host_st_t st_reg;
	ipc_pkg::ipc_host_ph_t ph_reg;
	logic [1:0] qph_reg;
	logic [3:0] bit_reg;
	logic [7:0] tx_reg;
	logic [7:0] rx_reg;
	logic [7:0] len_reg;
	logic [7:0] sub_reg;
	logic rd_reg;
	logic ackd_reg;
	logic scl_oe_reg;
	logic sda_oe_reg;
	logic pdn_reg;

	assign link.host_scl_o = 1'b0;
	assign link.host_sda_o = 1'b0;
	assign link.host_scl_oe = scl_oe_reg;
	assign link.host_sda_oe = sda_oe_reg;
	assign link.power_down_pin = pdn_reg;
	assign link.strap = STRAP;
	assign tick = (qcnt_reg == 16'(QTR - 1));

	////////////////////////////////////////////////////////////////////////////////
	// free-running quarter divider; the first quarter of a start may be short
	always_ff @(posedge i_clk_sys) begin
		if (i_rst || tick) begin
			qcnt_reg <= 16'h0000;
		end else begin
			qcnt_reg <= qcnt_reg + 16'h0001;
		end
	end

	// read data comes from another party, so it is synchronised
	always_ff @(posedge i_clk_sys) begin
		sda_sy_reg <= {sda_sy_reg[0], link.sda};
	end

	////////////////////////////////////////////////////////////////////////////////
	// transfer sequencer; no clock stretching is expected from the device
	always_ff @(posedge i_clk_sys) begin
		if (i_rst) begin
			st_reg <= ipc_pkg::HS_WAIT;
			ph_reg <= ipc_pkg::HP_ADDR_W;
			pdn_reg <= 1'b0;
			wcnt_reg <= 32'h0;
			scl_oe_reg <= 1'b0;
			sda_oe_reg <= 1'b0;
			qph_reg <= 2'h0;
			bit_reg <= 4'h0;
			tx_reg <= 8'h00;
			rx_reg <= 8'h00;
			len_reg <= 8'h00;
			sub_reg <= 8'h00;
			rd_reg <= 1'b0;
			ackd_reg <= 1'b0;
			o_ready <= 1'b0;
			o_nack <= 1'b0;
			o_rd_data <= 8'h00;
			o_rd_valid <= 1'b0;
			o_wr_take <= 1'b0;
		end else begin
			o_rd_valid <= 1'b0;
			o_wr_take <= 1'b0;
			unique case (st_reg)
				ipc_pkg::HS_WAIT: begin
					// release power-down, then hold off all traffic
					pdn_reg <= 1'b1;
					if (wcnt_reg == 32'(PDN_WAIT_CYC - 1)) begin
						st_reg <= ipc_pkg::HS_IDLE;
						o_ready <= 1'b1;
					end else begin
						wcnt_reg <= wcnt_reg + 32'h1;
					end
				end
				ipc_pkg::HS_IDLE: begin
					// book change is two single writes issued by the user in turn
					if (i_cmd_valid) begin
						o_ready <= 1'b0;
						o_nack <= 1'b0;
						rd_reg <= i_cmd_read;
						sub_reg <= i_cmd_sub;
						len_reg <= i_cmd_len;
						ph_reg <= ipc_pkg::HP_ADDR_W;
						tx_reg <= {ipc_pkg::ADDR_PREFIX, STRAP, 1'b0};
						qph_reg <= 2'h0;
						st_reg <= ipc_pkg::HS_START;
					end
				end
				ipc_pkg::HS_START: begin
					if (tick) begin
						qph_reg <= qph_reg + 2'h1;
						if (qph_reg == 2'h0) begin
							sda_oe_reg <= 1'b1;
						end else if (qph_reg == 2'h2) begin
							scl_oe_reg <= 1'b1;
						end else if (qph_reg == 2'h3) begin
							bit_reg <= 4'h0;
							st_reg <= ipc_pkg::HS_BIT;
						end
					end
				end
				ipc_pkg::HS_RSTART: begin
					if (tick) begin
						qph_reg <= qph_reg + 2'h1;
						unique case (qph_reg)
							2'h0: sda_oe_reg <= 1'b0;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b1;
							2'h3: begin
								scl_oe_reg <= 1'b1;
								bit_reg <= 4'h0;
								st_reg <= ipc_pkg::HS_BIT;
							end
						endcase
					end
				end
				ipc_pkg::HS_STOP: begin
					if (tick) begin
						qph_reg <= qph_reg + 2'h1;
						unique case (qph_reg)
							2'h0: sda_oe_reg <= 1'b1;
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: sda_oe_reg <= 1'b0;
							2'h3: begin
								o_ready <= 1'b1;
								st_reg <= ipc_pkg::HS_IDLE;
							end
						endcase
					end
				end
				ipc_pkg::HS_BIT: begin
					if (tick) begin
						qph_reg <= qph_reg + 2'h1;
						unique case (qph_reg)
							2'h0: begin
								if (bit_reg == 4'h8) begin
									// ack every read byte but the last
									sda_oe_reg <= (ph_reg == ipc_pkg::HP_RDATA) && (len_reg > 8'h01);
								end else begin
									sda_oe_reg <= (ph_reg != ipc_pkg::HP_RDATA) && !tx_reg[7];
								end
							end
							2'h1: scl_oe_reg <= 1'b0;
							2'h2: begin
								if (bit_reg == 4'h8) begin
									ackd_reg <= !sda_sy_reg[1];
								end else begin
									rx_reg <= {rx_reg[6:0], sda_sy_reg[1]};
									tx_reg <= {tx_reg[6:0], 1'b0};
								end
							end
							2'h3: begin
								scl_oe_reg <= 1'b1;
								if (bit_reg != 4'h8) begin
									bit_reg <= bit_reg + 4'h1;
								end else begin
									bit_reg <= 4'h0;
									if (ph_reg != ipc_pkg::HP_RDATA && !ackd_reg) begin
										o_nack <= 1'b1;
										st_reg <= ipc_pkg::HS_STOP;
									end else begin
										unique case (ph_reg)
											ipc_pkg::HP_ADDR_W: begin
												ph_reg <= ipc_pkg::HP_SUB;
												tx_reg <= sub_reg;
											end
											ipc_pkg::HP_SUB: begin
												if (rd_reg) begin
													ph_reg <= ipc_pkg::HP_ADDR_R;
													tx_reg <= {ipc_pkg::ADDR_PREFIX, STRAP, 1'b1};
													st_reg <= ipc_pkg::HS_RSTART;
												end else if (len_reg == 8'h00) begin
													st_reg <= ipc_pkg::HS_STOP;
												end else begin
													ph_reg <= ipc_pkg::HP_WDATA;
													tx_reg <= i_wr_data;
													o_wr_take <= 1'b1;
												end
											end
											ipc_pkg::HP_WDATA: begin
												// bytes go out in the user's order, sub-address rising
												len_reg <= len_reg - 8'h01;
												if (len_reg == 8'h01) begin
													st_reg <= ipc_pkg::HS_STOP;
												end else begin
													tx_reg <= i_wr_data;
													o_wr_take <= 1'b1;
												end
											end
											ipc_pkg::HP_ADDR_R: begin
												ph_reg <= ipc_pkg::HP_RDATA;
											end
											default: begin
												o_rd_data <= rx_reg;
												o_rd_valid <= 1'b1;
												len_reg <= len_reg - 8'h01;
												if (len_reg <= 8'h01) begin
													st_reg <= ipc_pkg::HS_STOP;
												end
											end
										endcase
									end
								end
							end
						endcase
					end
				end
				default: begin
					st_reg <= ipc_pkg::HS_IDLE;
				end
			endcase
		end
	end
endmodule

// ===== ipc_chk.sv
// concurrent checks on the i2c link between host and device
module ipc_chk (
	input wire logic i_clk_link,
	input wire logic scl,
	input wire logic sda,
	input wire logic dev_sda_oe,
	input wire logic power_down_pin,
	input wire logic [1:0] strap
);
	logic scl_q, sda_q, rw_q;
	logic [3:0] bit_cnt;
	logic [7:0] byte_cnt, shift_q;
	wire logic scl_rise = scl && !scl_q;
	// start or repeated start: sda falls while scl stays high
	wire logic start_seen = scl && scl_q && sda_q && !sda;
	default clocking cb @(posedge i_clk_link); endclocking
	default disable iff (!power_down_pin);
	////////////////////////////////////////
	// previous wire levels for edge detection
	always_ff @(posedge i_clk_link) begin
		scl_q <= scl;
		sda_q <= sda;
	end
	// bit and byte position since the last start, counts only
	always_ff @(posedge i_clk_link) begin
		if (!power_down_pin || start_seen) begin
			bit_cnt <= 4'h0;
			byte_cnt <= 8'h00;
		end else if (scl_rise) begin
			bit_cnt <= (bit_cnt == 4'h8) ? 4'h0 : bit_cnt + 4'h1;
			if (bit_cnt == 4'h8) byte_cnt <= byte_cnt + 8'h01;
		end
	end
	// received bits and the direction of the frame; no reset needed, filled before use
	always_ff @(posedge i_clk_link) begin
		if (scl_rise) shift_q <= {shift_q[6:0], sda};
		if (scl_rise && bit_cnt == 4'h8 && byte_cnt == 8'h00) rw_q <= shift_q[0];
	end
	////////////////////////////////////////
	AST_ADDR_ACK: assert property (scl_rise && bit_cnt == 4'h8 && byte_cnt == 8'h00 &&
		shift_q[7:1] == {ipc_pkg::ADDR_PREFIX, strap} |-> !sda) else $error("address not acked");
	AST_WRITE_ACK: assert property (scl_rise && bit_cnt == 4'h8 && byte_cnt != 8'h00 &&
		!rw_q |-> !sda) else $error("write byte not acked");
	AST_MASTER_ACK_FREE: assert property (scl_rise && bit_cnt == 4'h8 &&
		byte_cnt != 8'h00 && rw_q |-> !dev_sda_oe) else $error("device holds master ack bit");
	AST_NO_CLASH: assert property (scl_rise && bit_cnt != 4'h8 &&
		(byte_cnt == 8'h00 || !rw_q) |-> !dev_sda_oe) else $error("device drives host bits");
	AST_SDA_SCL_LOW: assert property ($changed(dev_sda_oe) |-> !scl && !$past(scl))
		else $error("device sda moved with scl high");
	AST_PDN_RELEASE: assert property ($rose(power_down_pin) |-> !dev_sda_oe [*4])
		else $error("device drives sda after power-down");
	AST_PDN_WAIT: assert property ($rose(power_down_pin) |-> scl [*8])
		else $error("traffic right after power-down release");
	AST_SCL_LOW_MIN: assert property ($fell(scl) |-> !scl [*8])
		else $error("scl low phase too short");
	AST_STRAP_STABLE: assert property ($stable(strap))
		else $error("strap moved while powered");
	cover property (scl_rise && bit_cnt == 4'h8 && byte_cnt == 8'h00 && shift_q[0]);
	cover property (scl_rise && bit_cnt == 4'h8 && byte_cnt == 8'h04 && !rw_q);
	cover property ($rose(power_down_pin));
endmodule

// ===== tb_top.sv
// bench: host and device joined over the link, checked against a byte model
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic i_clk_sys = 1'b0;
	logic i_clk_link = 1'b0;
	logic i_rst = 1'b1;
	logic i_cmd_valid = 1'b0;
	logic i_cmd_read = 1'b0;
	logic [7:0] i_cmd_sub = 8'h00;
	logic [7:0] i_cmd_len = 8'h00;
	logic [7:0] i_wr_data = 8'h00;
	logic o_ready, o_nack, o_rd_valid, o_wr_take, o_update;
	logic [7:0] o_rd_data, o_book, o_page;
	logic [1:0] o_dev_state;
	int mismatches = 0;
	int checks = 0;
	logic [31:0] seed = 32'h7;
	logic [7:0] m_page, m_book, m_crc, m_xor;
	logic [1:0] m_state;
	logic [7:0] wq[$];
	ipc_link_if link ();
	ipc_host #(.RATE_KHZ(400), .PDN_WAIT_CYC(200), .STRAP(2'h2)) ipc_host_i (
		.i_clk_sys(i_clk_sys), .i_rst(i_rst), .link(link), .i_cmd_valid(i_cmd_valid),
		.i_cmd_read(i_cmd_read), .i_cmd_sub(i_cmd_sub), .i_cmd_len(i_cmd_len),
		.i_wr_data(i_wr_data), .o_ready(o_ready), .o_nack(o_nack), .o_rd_data(o_rd_data),
		.o_rd_valid(o_rd_valid), .o_wr_take(o_wr_take));
	ipc_device ipc_device_i (.i_clk_sys(i_clk_sys), .i_rst(i_rst), .i_clk_link(i_clk_link),
		.link(link), .o_dev_state(o_dev_state), .o_book(o_book), .o_page(o_page),
		.o_update(o_update));
	ipc_chk ipc_chk_i (.i_clk_link(i_clk_link), .scl(link.scl), .sda(link.sda),
		.dev_sda_oe(link.dev_sda_oe), .power_down_pin(link.power_down_pin), .strap(link.strap));
	////////////////////////////////////////
	// two unrelated clocks, link clock free running
	initial begin
		forever #25 i_clk_sys = ~i_clk_sys;
	end
	initial begin
		#3.3;
		forever #7.5 i_clk_link = ~i_clk_link;
	end
	////////////////////////////////////////
	// xorshift source for data bytes
	function automatic logic [7:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed[7:0];
	endfunction
	// crc step msb first, no reflection
	function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
		logic [7:0] r;
		r = c ^ d;
		for (int i = 0; i < 8; i++) r = {r[6:0], 1'b0} ^ (r[7] ? ipc_pkg::CRC_POLY : 8'h00);
		return r;
	endfunction
	// model of one byte written at sub-address s
	task automatic m_write(input logic [7:0] s, input logic [7:0] d);
		if (s == 8'h00) m_page = d;
		else if (m_page == 8'h00 && s == 8'h7f) m_book = d;
		else if (m_page == 8'h00 && s == 8'h7e) m_crc = d;
		else begin
			m_crc = crc_step(m_crc, d);
			if (m_book == 8'h8c && m_page != 8'h00) m_xor = m_xor ^ d;
			if (m_book == 8'h8c && m_page == 8'h00 && s == 8'h7d) m_xor = d;
			if (m_book == 8'h00 && m_page == 8'h00 && s == 8'h03) m_state = d[1:0];
		end
	endtask
	// model of a read at sub-address s
	function automatic logic [7:0] m_read(input logic [7:0] s);
		if (s == 8'h00) return m_page;
		if (m_page != 8'h00) return 8'h00;
		if (s == 8'h7f) return m_book;
		if (s == 8'h7e) return m_crc;
		if (s == 8'h7d && m_book == 8'h8c) return m_xor;
		if (s == 8'h03 && m_book == 8'h00) return {6'h00, m_state};
		return 8'h00;
	endfunction
	////////////////////////////////////////
	task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask
	task automatic finish_test();
		$display("counts: %0d checks, %0d mismatches", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// inputs move 1 ns after the edge, outputs are read there too
	task automatic tick(input int n);
		repeat (n) @(posedge i_clk_sys);
		#1;
	endtask
	// one host command; write bytes come from wq, reads are compared per byte
	task automatic cmd(input logic rd, input logic [7:0] s, input int n);
		int k;
		int c;
		int u;
		logic [7:0] a;
		k = 0;
		c = 0;
		u = 0;
		a = s;
		while (o_ready !== 1'b1 && c < 30000) begin
			tick(1);
			c++;
		end
		i_cmd_valid = 1'b1;
		i_cmd_read = rd;
		i_cmd_sub = s;
		i_cmd_len = rd ? 8'(n) : 8'(wq.size());
		i_wr_data = (wq.size() > 0) ? wq[0] : 8'h00;
		tick(1);
		i_cmd_valid = 1'b0;
		while (o_ready !== 1'b1 && c < 30000) begin
			if (o_wr_take === 1'b1) begin
				m_write(a, wq[k]);
				a++;
				k++;
				i_wr_data = (k < wq.size()) ? wq[k] : 8'h00;
			end
			if (o_rd_valid === 1'b1) begin
				chk("read data", m_read(a), o_rd_data);
				a++;
			end
			// each committed byte shows one mirror refresh pulse
			if (o_update === 1'b1) u++;
			tick(1);
			c++;
		end
		if (c >= 30000) begin
			chk("ready", 8'h01, 8'h00);
			finish_test();
		end
		chk("nack", 8'h00, {7'h00, o_nack});
		chk("updates", 8'(wq.size()), 8'(u));
		wq.delete();
	endtask
	task automatic wr1(input logic [7:0] s, input logic [7:0] d);
		wq.push_back(d);
		cmd(1'b0, s, 0);
	endtask
	task automatic m_reset();
		{m_page, m_book, m_crc, m_xor, m_state} = '0;
	endtask
	////////////////////////////////////////
	// main sequence: selection, checksums, state field, second reset
	initial begin
		m_reset();
		tick(8);
		i_rst = 1'b0;
		wr1(8'h00, 8'h00);
		wr1(8'h7f, 8'h8c);
		chk("book", m_book, o_book);
		wr1(8'h7e, 8'h00);
		wr1(8'h7d, 8'h00);
		$display("test select done");
		wr1(8'h00, 8'hff);
		chk("page", m_page, o_page);
		for (int i = 0; i < 4; i++) wq.push_back(xs());
		cmd(1'b0, 8'h24, 0);
		wr1(8'h7f, xs());
		chk("book", m_book, o_book);
		cmd(1'b1, 8'h00, 1);
		wr1(8'h00, 8'h00);
		cmd(1'b1, 8'h7d, 3);
		cmd(1'b1, 8'h7e, 1);
		$display("test checksum done");
		wr1(8'h7f, 8'h00);
		for (int st = 0; st < 4; st++) begin
			wr1(8'h03, {xs() & 8'hfc} | 8'(st));
			chk("state", {6'h00, m_state}, {6'h00, o_dev_state});
			cmd(1'b1, 8'h03, 1);
		end
		wr1(8'h7e, xs());
		cmd(1'b1, 8'h7d, 2);
		$display("test state done");
		i_rst = 1'b1;
		tick(8);
		i_rst = 1'b0;
		m_reset();
		chk("book", 8'h00, o_book);
		cmd(1'b1, 8'h7e, 2);
		$display("test reset done");
		finish_test();
	end
endmodule
